/* hdl/bgmc_core.sv */
// module: conversion scheduling, results, charge count, capacity
//
// Summary of operation
// - measurement sequence repeats without pause while active.
// - divider supply stays off when temperature takes the second aux slot.
// - one full pass over all voltage slots takes 1760 ms.
// - battery voltage refreshed every 880 ms, two's complement, 1.22 mV step.
// - voltage above the largest value reads 7fff.
// - every 1024th conversion measures offset; next 1023 use it.
// - voltage result holds during the offset conversion.
// - current result also holds over the offset conversion.
// - divider supply is enabled before each aux conversion.
// - aux inputs alternate, each refreshed every 1760 ms.
// - aux result: sign, eleven magnitude bits, low four bits zero.
// - temperature refreshed every 1760 ms, 0.125 C step.
// - temperature replaces second aux only while its select bit is set.
// - current positive when sense input is below ground.
// - current refreshed every 880 ms at end of its conversion.
// - current saturates at 7fff and 8000.
// - offset bias added to raw current; used for report and count.
// - a bias write applies to every later current conversion.
// - bias is a signed byte, default 00.
// - accumulator adds each biased current, range 204.8 mVh.
// - charge scaled by initial or learned factor moves capacity.
// - capacity in 0.5 percent steps, clamped 0 to 100 percent.
// - capacity recomputed after each current and open-circuit update.
// - sleep stops conversions; registers stay accessible.
// - reading a word's upper byte latches it until command end.
`timescale 1ns/1ps
module bgmc_core #(
	parameter int P_SLOT_CYCLES = bgmc_pkg::SLOT_CYCLES
) (
	// clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     reset_in,
	// converter
	output logic                          adc_start_out,
	output logic [2:0]                    adc_channel_out,
	input  wire logic                     adc_done_in,
	input  wire logic signed [bgmc_pkg::ADC_W-1:0] adc_result_in,
	output logic                          vout_enable_out,
	// power mode
	input  wire logic                     sleep_in,
	// capacity inputs
	input  wire logic                     ocv_update_in,
	input  wire logic [7:0]               ocv_base_in,
	input  wire logic [7:0]               initial_scale_in,
	input  wire logic [7:0]               learned_scale_in,
	input  wire logic                     learned_valid_in,
	// register port
	input  wire logic                     reg_rd_in,
	input  wire logic                     reg_wr_in,
	input  wire logic [7:0]               reg_addr_in,
	input  wire logic [7:0]               reg_wdata_in,
	input  wire logic                     cmd_end_in,
	output logic [7:0]                    reg_rdata_out,
	// status
	output logic [7:0]                    rel_capacity_out
);
	import bgmc_pkg::*;

	typedef struct packed {
		bgmc_slot_t         slot;
		logic [31:0]        cnt;
		logic               aux_sel;
		logic               use_temp;
		logic [9:0]         conv;
		logic [2:0]         chan;
		logic signed [ADC_W-1:0] offs;
		logic [15:0]        volt;
		logic [15:0]        cur;
		logic [15:0]        aux0;
		logic [15:0]        aux1;
		logic [15:0]        temp;
		logic [7:0]         current_offset_bias;
		logic [7:0]         cfg;
		logic signed [31:0] acc;
		logic [7:0]         relcap;
		logic               recalc;
		logic               start;
		logic               vout;
		logic [7:0]         rdata;
		logic               lat_v;
		logic [6:0]         lat_a;
		logic [15:0]        lat;
	} bgmc_state_t;

	bgmc_state_t q;
	bgmc_state_t n;

	localparam logic [31:0] LAST_CNT = 32'(P_SLOT_CYCLES - 1);

	function automatic logic [15:0] sat16(
		input logic signed [19:0] v
	);
		if (v > 20'sh07fff) begin
			sat16 = 16'h7fff;
		end else if (v < -20'sh08000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	function automatic logic [11:0] sat12(
		input logic signed [19:0] v
	);
		if (v > 20'sh007ff) begin
			sat12 = 12'h7ff;
		end else if (v < -20'sh00800) begin
			sat12 = 12'h800;
		end else begin
			sat12 = v[11:0];
		end
	endfunction : sat12

	function automatic logic [15:0] reg_word(
		input bgmc_state_t s,
		input logic [7:0]  a
	);
		unique case ({a[7:1], 1'b0})
			ADDR_CFG & 8'hfe: reg_word = {8'h00, s.cfg};
			ADDR_RELCAP: reg_word = {s.relcap, 8'h00};
			ADDR_TEMP:   reg_word = s.temp;
			ADDR_AUX0:   reg_word = s.aux0;
			ADDR_AUX1:   reg_word = s.aux1;
			ADDR_VOLT:   reg_word = s.volt;
			ADDR_CURR:   reg_word = s.cur;
			ADDR_ACC:    reg_word = s.acc[31:16];
			ADDR_CURRENT_OFFSET_BIAS:   reg_word = {s.current_offset_bias, 8'h00};
			default:     reg_word = 16'h0000;
		endcase
	endfunction : reg_word

	logic signed [19:0] corr;
	logic signed [19:0] cur_raw;
	logic signed [32:0] acc_sum;
	logic signed [40:0] prod;
	logic signed [40:0] cap;
	logic [7:0]         scale;
	logic [15:0]        word;
	logic               internal_temp_select;

	always_comb begin
		n       = q;
		corr    = '0;
		cur_raw = '0;
		acc_sum = '0;
		prod    = '0;
		cap     = '0;
		scale   = '0;
		word    = '0;
		internal_temp_select   = q.cfg[CFG_INTERNAL_TEMP_SELECT];
		n.start = 1'b0;

		// slot timer, frozen in sleep
		if (sleep_in) begin
			n.vout = 1'b0;
			// pre slot restarts so the supply settles again
			if (q.slot == ST_PRE) begin
				n.cnt = '0;
			end
		end else if (q.cnt == LAST_CNT) begin
			n.cnt = '0;
			unique case (q.slot)
				ST_PRE: begin
					n.slot  = ST_AUX;
					n.start = 1'b1;
					if (!q.aux_sel) begin
						n.chan = CH_AUX0;
					end else if (q.use_temp) begin
						n.chan = CH_TEMP;
					end else begin
						n.chan = CH_AUX1;
					end
				end
				ST_AUX: begin
					n.slot  = ST_VOLT;
					n.start = 1'b1;
					n.chan  = CH_VOLT;
					n.vout  = 1'b0;
				end
				ST_VOLT: begin
					n.slot  = ST_CURR;
					n.start = 1'b1;
					n.chan  = CH_CURR;
				end
				ST_CURR: begin
					n.slot    = ST_PRE;
					n.aux_sel = !q.aux_sel;
					// choice fixed for the whole pre slot
					n.use_temp = !q.aux_sel && internal_temp_select;
					n.vout     = !n.use_temp;
				end
			endcase
			if (n.start) begin
				n.conv = q.conv + 10'h001;
				if (q.conv == OFFS_CONV_IDX) begin
					n.chan = CH_OFFS;
				end
			end
		end else begin
			n.cnt = q.cnt + 32'h0000_0001;
		end
		if (!sleep_in && q.slot == ST_PRE) begin
			n.vout = !q.use_temp;
		end

		// conversion results
		corr = 20'(adc_result_in) - 20'(q.offs);
		if (adc_done_in) begin
			unique case (q.chan)
				CH_OFFS: n.offs = adc_result_in;
				CH_VOLT: n.volt = sat16(corr);
				CH_AUX0: n.aux0 = {sat12(corr), 4'h0};
				CH_AUX1: n.aux1 = {sat12(corr), 4'h0};
				CH_TEMP: n.temp = sat16(corr);
				CH_CURR: begin
					// sign flipped: sense below ground is charge
					cur_raw = -corr
						+ 20'($signed(q.current_offset_bias));
					n.cur = sat16(cur_raw);
					acc_sum = 33'(q.acc)
						+ 33'($signed(n.cur));
					if (acc_sum > 33'(ACC_LIMIT)) begin
						n.acc = ACC_LIMIT;
					end else if (acc_sum < -33'(ACC_LIMIT)) begin
						n.acc = -ACC_LIMIT;
					end else begin
						n.acc = acc_sum[31:0];
					end
					n.recalc = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// relative capacity
		scale = learned_valid_in ? learned_scale_in
			: initial_scale_in;
		if (ocv_update_in) begin
			n.acc    = '0;
			n.recalc = 1'b0;
			if (ocv_base_in > RELCAP_MAX) begin
				n.relcap = RELCAP_MAX;
			end else begin
				n.relcap = ocv_base_in;
			end
		end else if (q.recalc) begin
			n.recalc = 1'b0;
			prod = 41'(q.acc) * $signed({33'h0, scale});
			cap  = (prod >>> RELCAP_SHIFT)
				+ $signed({33'h0, ocv_base_in});
			if (cap < 41'sh0) begin
				n.relcap = 8'h00;
			end else if (cap > $signed({33'h0, RELCAP_MAX})) begin
				n.relcap = RELCAP_MAX;
			end else begin
				n.relcap = cap[7:0];
			end
		end

		// register writes
		if (reg_wr_in) begin
			if (reg_addr_in == ADDR_CURRENT_OFFSET_BIAS) begin
				n.current_offset_bias = reg_wdata_in;
			end else if (reg_addr_in == ADDR_CFG) begin
				n.cfg = reg_wdata_in;
			end
		end

		// register reads with word latch
		word = reg_word(q, reg_addr_in);
		if (cmd_end_in) begin
			n.lat_v = 1'b0;
		end else if (reg_rd_in) begin
			if (!reg_addr_in[0]) begin
				n.lat_v = 1'b1;
				n.lat_a = reg_addr_in[7:1];
				n.lat   = word;
				n.rdata = word[15:8];
			end else if (q.lat_v && q.lat_a == reg_addr_in[7:1]) begin
				n.rdata = q.lat[7:0];
			end else begin
				n.rdata = word[7:0];
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			q         <= '0;
			q.slot    <= ST_PRE;
			q.vout    <= 1'b1;
			q.current_offset_bias    <= CURRENT_OFFSET_BIAS_RESET;
			q.cfg     <= CFG_RESET;
		end else begin
			q <= n;
		end
	end

	assign adc_start_out    = q.start;
	assign adc_channel_out  = q.chan;
	assign vout_enable_out  = q.vout;
	assign reg_rdata_out    = q.rdata;
	assign rel_capacity_out = q.relcap;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	a_temp_vout_off: assert property (
		q.slot == ST_AUX && q.chan == CH_TEMP |-> !vout_enable_out)
		else $error("divider supply on during temperature slot");

	a_aux_vout_on: assert property (
		adc_start_out && (adc_channel_out == CH_AUX0
			|| adc_channel_out == CH_AUX1)
		|-> vout_enable_out && $past(vout_enable_out))
		else $error("aux conversion without settled supply");

	a_slot_length: assert property (
		q.cnt == LAST_CNT && !sleep_in && q.slot != ST_CURR
		|=> adc_start_out)
		else $error("no conversion at slot boundary");

	a_start_spacing: assert property (
		adc_start_out |=> !adc_start_out [*2])
		else $error("conversions started too close together");

	a_volt_hold: assert property (
		adc_done_in && q.chan == CH_OFFS |=> $stable(q.volt)
			&& $stable(q.cur))
		else $error("result changed by offset conversion");

	a_offset_slot: assert property (
		adc_start_out && $past(q.conv) == OFFS_CONV_IDX
		|-> adc_channel_out == CH_OFFS)
		else $error("offset conversion not on 1024th slot");

	a_aux_low_zero: assert property (
		q.aux0[3:0] == 4'h0 && q.aux1[3:0] == 4'h0)
		else $error("aux reserved bits not zero");

	a_relcap_range: assert property (
		rel_capacity_out <= RELCAP_MAX)
		else $error("capacity above full");

	a_acc_range: assert property (
		q.acc <= ACC_LIMIT && q.acc >= -ACC_LIMIT)
		else $error("accumulator outside range");

	a_sleep_idle: assert property (
		sleep_in |=> !adc_start_out)
		else $error("conversion started in sleep");

	a_latch_hold: assert property (
		q.lat_v && !cmd_end_in && !(reg_rd_in && !reg_addr_in[0])
		|=> $stable(q.lat))
		else $error("latched word changed during command");

	a_current_offset_bias_write: assert property (
		reg_wr_in && reg_addr_in == ADDR_CURRENT_OFFSET_BIAS
		|=> q.current_offset_bias == $past(reg_wdata_in))
		else $error("bias write not taken");

	a_relcap_ocv: assert property (
		ocv_update_in && ocv_base_in <= RELCAP_MAX
		|=> rel_capacity_out == $past(ocv_base_in) && q.acc == 0)
		else $error("capacity not reloaded on open-circuit update");

	a_cfg_write: assert property (
		reg_wr_in && reg_addr_in == ADDR_CFG
		|=> q.cfg == $past(reg_wdata_in))
		else $error("configuration write not taken");

	a_sleep_vout: assert property (
		sleep_in |=> !vout_enable_out)
		else $error("divider supply on in sleep");
endmodule : bgmc_core

/* hdl/bgmc_pkg.sv */
// package: constants and types of the measurement core
package bgmc_pkg;
	localparam int CLK_MHZ       = 250;
	localparam int SEQ_MS        = 1760;
	localparam int SLOTS_PER_SEQ = 8;
	localparam int SLOT_MS       = SEQ_MS / SLOTS_PER_SEQ;
	localparam int SLOT_CYCLES   = SLOT_MS * CLK_MHZ * 1000;
	localparam int ADC_W         = 18;

	localparam logic [9:0] OFFS_CONV_IDX = 10'h3ff;

	localparam logic [2:0] CH_VOLT = 3'h0;
	localparam logic [2:0] CH_CURR = 3'h1;
	localparam logic [2:0] CH_AUX0 = 3'h2;
	localparam logic [2:0] CH_AUX1 = 3'h3;
	localparam logic [2:0] CH_TEMP = 3'h4;
	localparam logic [2:0] CH_OFFS = 3'h5;

	localparam logic [7:0] ADDR_CFG    = 8'h01;
	localparam logic [7:0] ADDR_RELCAP = 8'h02;
	localparam logic [7:0] ADDR_TEMP   = 8'h04;
	localparam logic [7:0] ADDR_AUX0   = 8'h08;
	localparam logic [7:0] ADDR_AUX1   = 8'h0a;
	localparam logic [7:0] ADDR_VOLT   = 8'h0c;
	localparam logic [7:0] ADDR_CURR   = 8'h0e;
	localparam logic [7:0] ADDR_ACC    = 8'h10;
	localparam logic [7:0] ADDR_CURRENT_OFFSET_BIAS   = 8'h12;

	localparam logic [7:0] CURRENT_OFFSET_BIAS_RESET  = 8'h00;
	localparam logic [7:0] CFG_RESET   = 8'h00;
	localparam int         CFG_INTERNAL_TEMP_SELECT   = 0;

	localparam logic signed [31:0] ACC_LIMIT = 32'sh01ff5d17;
	localparam logic [7:0] RELCAP_MAX   = 8'hc8;
	localparam int         RELCAP_SHIFT = 20;

	typedef enum logic [3:0] {
		ST_PRE  = 4'h1,
		ST_AUX  = 4'h2,
		ST_VOLT = 4'h4,
		ST_CURR = 4'h8
	} bgmc_slot_t;
endpackage : bgmc_pkg

/* test/bgmc_adc_model.sv */
// converter and analog front end facing the measurement core
`timescale 1ns/1ps
module bgmc_adc_model #(
	parameter int LAT = 7
) (
	// clock
	input  wire logic                       clk_in,
	// conversion request
	input  wire logic                       start_in,
	input  wire logic [2:0]                 chan_in,
	// conversion answer
	output logic                            done_out,
	output logic signed [bgmc_pkg::ADC_W-1:0] res_out
);
	import bgmc_pkg::*;
	logic signed [ADC_W-1:0] raw [0:5];
	logic [2:0]              ch;
	logic                    fire;
	int                      cnt;
	initial begin
		done_out = 1'b0;
		res_out  = 18'sh2aaaa;
		cnt      = 0;
		ch       = '0;
		foreach (raw[i]) raw[i] = '0;
	end
	// one answer per request, fixed latency; idle bus toggles
	always @(negedge clk_in) begin
		fire = !start_in && cnt == 1;
		if (start_in) begin
			ch  = chan_in;
			cnt = LAT;
		end else if (cnt > 0) begin
			cnt = cnt - 1;
		end
		done_out <= fire;
		res_out  <= fire ? raw[ch] : ~res_out;
	end
endmodule : bgmc_adc_model

/* test/tb_top.sv */
// self-checking bench of the measurement core
`timescale 1ns/1ps
module tb_top;
	import bgmc_pkg::*;
	localparam int SLOT = 20;
	localparam int LAT  = 7;
	localparam logic signed [17:0] PMAX = 18'sh1ffff;
	localparam logic signed [17:0] NMAX = 18'sh20001;
	logic        clk_in, reset_in, sleep_in, ocv_update_in;
	logic        learned_valid_in, reg_rd_in, reg_wr_in, cmd_end_in;
	logic        adc_start_out, adc_done_in, vout_enable_out;
	logic [2:0]  adc_channel_out;
	logic [7:0]  ocv_base_in, initial_scale_in, learned_scale_in;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [7:0]  rel_capacity_out;
	logic signed [ADC_W-1:0] adc_result_in;
	logic [7:0]  bias [3] = '{8'h80, 8'h7f, 8'h00};
	int          n_errors = 0, checks = 0, cyc = 0, n_starts = 0;
	int          vout_run = 0, t0, t1, t2, n1;
	int          n_ch [8] = '{default: 0};

	bgmc_core #(.P_SLOT_CYCLES(SLOT)) dut_u (.clk_in, .reset_in,
		.adc_start_out, .adc_channel_out, .adc_done_in, .adc_result_in,
		.vout_enable_out, .sleep_in, .ocv_update_in, .ocv_base_in,
		.initial_scale_in, .learned_scale_in, .learned_valid_in,
		.reg_rd_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .cmd_end_in,
		.reg_rdata_out, .rel_capacity_out);
	bgmc_adc_model #(.LAT(LAT)) m_u (.clk_in(clk_in),
		.start_in(adc_start_out), .chan_in(adc_channel_out),
		.done_out(adc_done_in), .res_out(adc_result_in));

	task automatic results();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(negedge clk_in);
	endtask : tick
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		{reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
		tick(1);
		reg_wr_in = 1'b0;
		tick(1);
	endtask : wr_reg
	task automatic rd_chk(string n, logic [7:0] a, logic [7:0] e,
		logic [7:0] m = 8'hff);
		{reg_rd_in, reg_addr_in} = {1'b1, a};
		tick(1);
		reg_rd_in = 1'b0;
		chk(n, {8'h00, e & m}, {8'h00, reg_rdata_out & m});
		tick(1);
	endtask : rd_chk
	task automatic end_cmd();
		cmd_end_in = 1'b1;
		tick(1);
		cmd_end_in = 1'b0;
		tick(1);
	endtask : end_cmd
	task automatic chk_reg(string n, logic [7:0] a, logic [15:0] m,
		logic [15:0] e);
		rd_chk(n, a, e[15:8], m[15:8]);
		rd_chk(n, a + 8'h01, e[7:0], m[7:0]);
		end_cmd();
	endtask : chk_reg
	task automatic wait_start(logic [2:0] ch, output int t);
		t = -1;
		for (int i = 0; i < 2000 && t < 0; i++) begin
			@(negedge clk_in);
			if (adc_start_out === 1'b1 && adc_channel_out === ch) t = cyc;
		end
		if (t < 0) begin
			n_errors++;
			$display("wrong value start %0d exp seen got none", ch);
			results();
		end
	endtask : wait_start
	task automatic conv(logic [2:0] ch);
		wait_start(ch, t2);
		tick(LAT + 3);
	endtask : conv
	task automatic cap_step(logic [7:0] b);
		conv(CH_CURR);
		{ocv_update_in, ocv_base_in} = {1'b1, b};
		tick(1);
		ocv_update_in = 1'b0;
		tick(2);
		chk("cap ocv", {8'h00, b}, {8'h00, rel_capacity_out});
		conv(CH_CURR);
	endtask : cap_step

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	always @(posedge clk_in) cyc <= cyc + 1;
	// slot monitor
	always @(negedge clk_in) begin
		vout_run <= vout_enable_out ? vout_run + 1 : 0;
		if (adc_start_out === 1'b1) begin
			n_starts <= n_starts + 1;
			n_ch[adc_channel_out] <= n_ch[adc_channel_out] + 1;
			chk("offset slot", 16'((n_starts % 1024) == 1023),
				16'(adc_channel_out == CH_OFFS));
			if (adc_channel_out == CH_AUX0 || adc_channel_out == CH_AUX1)
				chk("vout settle", 16'h1, 16'(vout_run >= SLOT - 1));
			if (adc_channel_out == CH_TEMP)
				chk("vout temp", 16'h0, 16'(vout_enable_out));
		end
	end

	initial begin
		{sleep_in, ocv_update_in, learned_valid_in, cmd_end_in} = '0;
		{reg_rd_in, reg_wr_in, reg_addr_in, reg_wdata_in} = '0;
		{ocv_base_in, learned_scale_in} = '0;
		initial_scale_in = 8'hff;
		reset_in = 1'b1;
		tick(4);
		reset_in = 1'b0;
		chk("reset vout", 16'h1, 16'(vout_enable_out));
		m_u.raw[CH_VOLT] = PMAX;
		m_u.raw[CH_CURR] = PMAX;
		m_u.raw[CH_AUX0] = NMAX;
		m_u.raw[CH_AUX1] = PMAX;
		rd_chk("cfg", ADDR_CFG, 8'h00);
		rd_chk("bias", ADDR_CURRENT_OFFSET_BIAS, CURRENT_OFFSET_BIAS_RESET);
		rd_chk("unmapped", 8'h40, 8'h00);
		wait_start(CH_AUX0, t0);
		wait_start(CH_AUX1, t1);
		chk("aux alt", 16'(4 * SLOT), 16'(t1 - t0));
		wait_start(CH_VOLT, t1);
		wait_start(CH_VOLT, t2);
		chk("volt period", 16'(4 * SLOT), 16'(t2 - t1));
		wait_start(CH_CURR, t1);
		wait_start(CH_CURR, t2);
		chk("curr period", 16'(4 * SLOT), 16'(t2 - t1));
		wait_start(CH_AUX0, t1);
		chk("seq period", 16'h0, 16'((t1 - t0) % (8 * SLOT)));
		chk_reg("volt sat", ADDR_VOLT, 16'hffff, 16'h7fff);
		chk_reg("curr dis", ADDR_CURR, 16'hffff, 16'h8000);
		chk_reg("aux0", ADDR_AUX0, 16'h800f, 16'h8000);
		chk_reg("aux1", ADDR_AUX1, 16'h800f, 16'h0000);
		m_u.raw[CH_CURR] = NMAX;
		conv(CH_CURR);
		chk_reg("curr chg", ADDR_CURR, 16'hffff, 16'h7fff);
		m_u.raw[CH_CURR] = '0;
		foreach (bias[i]) begin
			wr_reg(ADDR_CURRENT_OFFSET_BIAS, bias[i]);
			rd_chk("bias", ADDR_CURRENT_OFFSET_BIAS, bias[i]);
			conv(CH_CURR);
			chk_reg("curr bias", ADDR_CURR, 16'hffff,
				{{8{bias[i][7]}}, bias[i]});
		end
		$display("test measurements done");
		rd_chk("volt hi", ADDR_VOLT, 8'h7f);
		m_u.raw[CH_VOLT] = '0;
		conv(CH_VOLT);
		rd_chk("volt lo", ADDR_VOLT + 8'h01, 8'hff);
		end_cmd();
		chk_reg("volt new", ADDR_VOLT, 16'hffff, 16'h0000);
		m_u.raw[CH_VOLT] = PMAX;
		m_u.raw[CH_TEMP] = 18'sh000c8;
		wr_reg(ADDR_CFG, 8'h01);
		rd_chk("cfg set", ADDR_CFG, 8'h01);
		wait_start(CH_TEMP, t0);
		n1 = n_ch[CH_AUX1];
		tick(10 * SLOT);
		chk("aux1 skipped", 16'(n1), 16'(n_ch[CH_AUX1]));
		chk_reg("temp", ADDR_TEMP, 16'hffff, 16'h00c8);
		wr_reg(ADDR_CFG, 8'h00);
		wait_start(CH_AUX1, t0);
		$display("test latch and temp done");
		m_u.raw[CH_CURR] = NMAX;
		cap_step(8'hc8);
		chk("cap hi", 16'h00c8, 16'(rel_capacity_out));
		cap_step(8'h64);
		chk("cap rise", 16'h1, 16'(rel_capacity_out > 8'h64));
		learned_valid_in = 1'b1;
		cap_step(8'h64);
		chk("cap learned", 16'h0064, 16'(rel_capacity_out));
		learned_valid_in = 1'b0;
		m_u.raw[CH_CURR] = PMAX;
		cap_step(8'h00);
		chk("cap lo", 16'h0000, 16'(rel_capacity_out));
		$display("test capacity done");
		sleep_in = 1'b1;
		tick(2);
		n1 = n_starts;
		tick(10 * SLOT);
		chk("sleep starts", 16'(n1), 16'(n_starts));
		wr_reg(ADDR_CURRENT_OFFSET_BIAS, 8'h11);
		rd_chk("sleep bias", ADDR_CURRENT_OFFSET_BIAS, 8'h11);
		wr_reg(ADDR_CURRENT_OFFSET_BIAS, 8'h00);
		sleep_in = 1'b0;
		m_u.raw[CH_OFFS] = 18'sh00010;
		wait_start(CH_VOLT, t0);
		for (int i = 0; i < 40000 && n_starts < 1024; i++) tick(1);
		chk("offset reached", 16'h1, 16'(n_starts >= 1024));
		tick(LAT + 3);
		chk_reg("volt hold", ADDR_VOLT, 16'hffff, 16'h7fff);
		chk_reg("curr hold", ADDR_CURR, 16'hffff, 16'h8000);
		m_u.raw[CH_VOLT] = 18'sh00110;
		conv(CH_VOLT);
		chk_reg("volt offs", ADDR_VOLT, 16'hffff, 16'h0100);
		$display("test sleep and offset done");
		results();
	end
endmodule : tb_top
